// [pis_pkg.sv]
// Package with constants and types for the processor init sequencer.
package pis_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned FAIL_DELAY_CYC = 4;
    localparam int unsigned BIST_CYC = 64;
    localparam int unsigned CSUM_WORDS = 8;
    localparam int unsigned CSUM_AW = 3;
    localparam int unsigned PTR_WORD_A = 1;
    localparam int unsigned PTR_WORD_B = 2;
    localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [31:0] CSUM_GOOD = 32'h0000_0000;
    localparam int unsigned INT_W = 4;

    typedef enum logic [7:0] {
        PIS_IDLE = 8'h01,
        PIS_DLY  = 8'h02,
        PIS_BIST = 8'h04,
        PIS_WAIT = 8'h08,
        PIS_FET  = 8'h10,
        PIS_CHK  = 8'h20,
        PIS_RUN  = 8'h40,
        PIS_STOP = 8'h80
    } pis_state_t;
endpackage

// [pis_fetch.sv]
// Checksum word fetcher that reads consecutive words and sums them.
`timescale 1ns/1ps
module pis_fetch
    import pis_pkg::*;
#(
    parameter int unsigned WORDS = CSUM_WORDS
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    output logic o_req,
    output logic [31:0] o_addr,
    input wire logic i_rdy,
    input wire logic [31:0] i_data,
    output logic o_done,
    output logic [31:0] o_sum,
    output logic [31:0] o_ptr_a,
    output logic [31:0] o_ptr_b
);
    logic [CSUM_AW:0] cnt_r;
    logic busy_r;

    assign o_req = busy_r;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            busy_r <= 1'b0;
            cnt_r <= '0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !busy_r) begin
                busy_r <= 1'b1;
                cnt_r <= '0;
            end else if (busy_r && i_rdy) begin
                cnt_r <= cnt_r + 1'b1;
                if (32'(cnt_r) == WORDS - 1) begin
                    busy_r <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

    // Eight words from the boot address. R8
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_addr <= BOOT_ADDR;
        end else if (i_start && !busy_r) begin
            o_addr <= BOOT_ADDR;
        end else if (busy_r && i_rdy) begin
            o_addr <= o_addr + WORD_BYTES;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_sum <= '0;
            o_ptr_a <= '0;
            o_ptr_b <= '0;
        end else if (i_start && !busy_r) begin
            o_sum <= '0;
        end else if (busy_r && i_rdy) begin
            o_sum <= o_sum + i_data;
            if (32'(cnt_r) == PTR_WORD_A) begin
                o_ptr_a <= i_data; // R10
            end
            if (32'(cnt_r) == PTR_WORD_B) begin
                o_ptr_b <= i_data; // R10
            end
        end
    end
endmodule

// [pis_top.sv]
// Reset and initialization sequencer with failure and bad-access signals.
// Notes on behaviour
// R1 - Reset held at least 41 double-rate cycles.
// R2 - Sample role and startup straps at release.
// R3 - Role strap high primary, low secondary.
// R4 - Startup strap high runs active initialization.
// R5 - Failure asserted shortly after release, through self-test.
// R6 - Self-test fault keeps failure, enters stop.
// R7 - Passing self-test deasserts failure.
// R8 - Initializer sums eight words from zero.
// R9 - Bad checksum reasserts failure, stops forever.
// R10 - Good checksum loads data structure pointers; the fetcher loads words 1 and 2 as pointers even on a bad checksum.
// R11 - Clear latched interrupts before first instruction.
// R12 - Sample bad access cycle after last ready.
// R13 - Synchronous move/load bad access is recoverable.
// R14 - During reset, bus idle and outputs deasserted.
// R15 - Reset source aligns edges to clock.
// R16 - Non-initializer idles until started externally.
// R17 - Stopped state left only by reset.
`timescale 1ns/1ps
module pis_top
    import pis_pkg::*;
#(
    parameter int unsigned FAIL_DLY = FAIL_DELAY_CYC,
    parameter int unsigned BIST_LEN = BIST_CYC,
    parameter int unsigned IW = INT_W
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_interrupt0_pin,
    input wire logic i_bad_access_in,
    input wire logic i_bist_fault,
    input wire logic i_start_cmd,
    input wire logic i_last_ready,
    input wire logic i_sync_op,
    input wire logic [IW-1:0] i_int_req,
    input wire logic i_mem_rdy,
    input wire logic [31:0] i_mem_data,
    output logic o_mem_req,
    output logic [31:0] o_mem_addr,
    output logic o_failure_n_out,
    output logic o_failure_n_oe,
    output logic o_primary_bus_master,
    output logic o_secondary_bus_master,
    output logic o_running,
    output logic o_stopped,
    output logic [31:0] o_ptr_a,
    output logic [31:0] o_ptr_b,
    output logic [IW-1:0] o_int_latched,
    output logic o_fatal_err,
    output logic o_recov_err
);
    pis_state_t state_r;
    pis_state_t state_nxt;
    logic rst_q_r;
    logic role_r;
    logic startup_r;
    logic fail_r;
    logic [15:0] cnt_r;
    logic fetch_start;
    logic fetch_done;
    logic fetch_req;
    logic [31:0] fetch_addr;
    logic [31:0] sum;
    logic bad_q_r;

    // The phase counter saturates so a stalled state can never wrap
    // around into a false limit hit.
    localparam logic [15:0] CNT_SAT = 16'hffff;

    // True on the last cycle of a phase that lasts lim cycles.
    function automatic logic cnt_hit(input logic [15:0] c,
                                     input int unsigned lim);
        cnt_hit = (32'(c) + 1 >= lim);
    endfunction

    pis_fetch #(.WORDS(CSUM_WORDS)) pis_fetch_inst (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_start(fetch_start),
        .o_req(fetch_req),
        .o_addr(fetch_addr),
        .i_rdy(i_mem_rdy),
        .i_data(i_mem_data),
        .o_done(fetch_done),
        .o_sum(sum),
        .o_ptr_a(o_ptr_a),
        .o_ptr_b(o_ptr_b)
    );

    // The host reset logic guarantees hold time and alignment. R1 R15
    always_ff @(posedge i_clk) begin
        rst_q_r <= i_rstn;
    end

    // Straps are caught in the first cycle after reset release. R2
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            role_r <= 1'b0;
            startup_r <= 1'b0;
            o_secondary_bus_master <= 1'b0; // R14
        end else if (!rst_q_r) begin
            role_r <= i_interrupt0_pin; // R2
            startup_r <= i_bad_access_in; // R2
            o_secondary_bus_master <= !i_interrupt0_pin; // R3
        end
    end

    // A fault or a bad checksum ends in stop, and only reset leaves it,
    // so a broken board never starts running half initialized.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PIS_IDLE: state_nxt = PIS_DLY;
            PIS_DLY: begin
                if (cnt_hit(cnt_r, FAIL_DLY)) begin
                    state_nxt = PIS_BIST; // R5
                end
            end
            PIS_BIST: begin
                if (i_bist_fault) begin
                    state_nxt = PIS_STOP; // R6
                end else if (cnt_hit(cnt_r, BIST_LEN)) begin
                    state_nxt = startup_r ? PIS_FET : PIS_WAIT; // R4
                end
            end
            PIS_WAIT: begin
                if (i_start_cmd) begin
                    state_nxt = PIS_RUN; // R16
                end
            end
            PIS_FET: state_nxt = PIS_CHK;
            PIS_CHK: begin
                if (fetch_done) begin
                    state_nxt = (sum == CSUM_GOOD) ? PIS_RUN : PIS_STOP; // R9
                end
            end
            PIS_RUN: state_nxt = PIS_RUN;
            PIS_STOP: state_nxt = PIS_STOP; // R17
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn || !rst_q_r) begin
            state_r <= PIS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn || state_nxt != state_r) begin
            cnt_r <= '0;
        end else if (cnt_r != CNT_SAT) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    assign fetch_start = (state_r == PIS_FET); // R8

    // Failure is held through self-test and any stop. R5 R6 R7 R9
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            fail_r <= 1'b0; // R14
        end else begin
            fail_r <= (state_nxt == PIS_BIST) || (state_nxt == PIS_STOP);
        end
    end

    // Open-drain failure pin: pulled low only while failing.
    assign o_failure_n_out = 1'b0;
    assign o_failure_n_oe = fail_r;

    assign o_primary_bus_master = role_r; // R3
    // Gated by reset so no request leaks out before the fetcher clears.
    assign o_mem_req = fetch_req && i_rstn; // R14
    assign o_mem_addr = fetch_addr;

    // Status pins are registered from the next state, so they change on
    // the same edge as state_r with no decode path to the pins.
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !rst_q_r) begin
            o_running <= 1'b0;
            o_stopped <= 1'b0;
        end else begin
            o_running <= (state_nxt == PIS_RUN);
            o_stopped <= (state_nxt == PIS_STOP); // R17
        end
    end

    // Requests before run are discarded so no stale request fires. R11
    always_ff @(posedge i_clk) begin
        if (!i_rstn || state_r != PIS_RUN) begin
            o_int_latched <= '0; // R11
        end else begin
            o_int_latched <= o_int_latched | i_int_req;
        end
    end

    // Bad access is looked at only one cycle after the final ready. R12
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            bad_q_r <= 1'b0;
        end else begin
            bad_q_r <= i_last_ready && o_running;
        end
    end

    // The sync-op level travels with bad access, so the two error pulses
    // can never both fire for one transfer.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_fatal_err <= 1'b0;
            o_recov_err <= 1'b0;
        end else begin
            o_fatal_err <= bad_q_r && i_bad_access_in && !i_sync_op; // R12
            o_recov_err <= bad_q_r && i_bad_access_in && i_sync_op; // R13
        end
    end
endmodule

// [pis_top_chk.sv]
// Port assertions for the init sequencer.
`timescale 1ns/1ps
module pis_top_chk
    import pis_pkg::*;
#(
    parameter int unsigned FAIL_DLY = FAIL_DELAY_CYC,
    parameter int unsigned BIST_LEN = BIST_CYC,
    parameter int unsigned IW = INT_W
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_bad_access_in,
    input wire logic i_last_ready,
    input wire logic i_sync_op,
    input wire logic i_mem_rdy,
    input wire logic o_mem_req,
    input wire logic [31:0] o_mem_addr,
    input wire logic o_failure_n_oe,
    input wire logic o_running,
    input wire logic o_stopped,
    input wire logic [IW-1:0] o_int_latched,
    input wire logic o_fatal_err,
    input wire logic o_recov_err
);
    localparam int FD = FAIL_DLY + 4;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_acc; o_running && i_last_ready ##1 i_bad_access_in; endsequence
    property p_quiet;
        disable iff (1'b0) !i_rstn [*2] |-> !o_mem_req && !o_failure_n_oe;
    endproperty
    property p_fail_on; $rose(i_rstn) |-> ##[1:FD] o_failure_n_oe; endproperty
    property p_bist; $rose(o_failure_n_oe) |-> o_failure_n_oe [*4]; endproperty
    property p_stop; o_stopped |=> o_stopped && o_failure_n_oe && !o_mem_req;
    endproperty
    property p_addr0; $rose(o_mem_req) |-> o_mem_addr == BOOT_ADDR; endproperty
    property p_step;
        o_mem_req && i_mem_rdy ##1 o_mem_req |->
            o_mem_addr == $past(o_mem_addr) + WORD_BYTES;
    endproperty
    property p_intclr; $rose(o_running) |-> o_int_latched == '0; endproperty
    property p_fatal; s_acc ##0 !i_sync_op |=> o_fatal_err; endproperty
    property p_recov; s_acc ##0 i_sync_op |=> o_recov_err; endproperty
    a_quiet: assert property (p_quiet) else $error("active in reset");
    a_fail_on: assert property (p_fail_on) else $error("no failure");
    a_bist: assert property (p_bist) else $error("failure dropped");
    a_stop: assert property (p_stop) else $error("stop left");
    a_addr0: assert property (p_addr0) else $error("bad first addr");
    a_step: assert property (p_step) else $error("bad addr step");
    a_intclr: assert property (p_intclr) else $error("irq not clear");
    a_fatal: assert property (p_fatal) else $error("no fatal");
    a_recov: assert property (p_recov) else $error("no recov");
    c_run: cover property ($rose(o_running));
    c_stop: cover property ($rose(o_stopped));
    c_recov: cover property (o_recov_err);
endmodule
bind pis_top pis_top_chk #(.FAIL_DLY(FAIL_DLY), .BIST_LEN(BIST_LEN), .IW(IW))
    pis_top_chk_inst (.*);

// [pis_mem_model.sv]
// Boot memory model that stalls every other cycle.
`timescale 1ns/1ps
module pis_mem_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_seed,
    input wire logic i_bad,
    output logic o_rdy,
    output logic [31:0] o_data
);
    logic slow_r;
    logic [31:0] w;
    always_ff @(posedge i_clk) slow_r <= i_req & ~slow_r;
    // Last word cancels the others, so a good image sums to zero.
    assign w = (i_addr[4:2] == 3'h7) ? {31'h0, i_bad} - i_seed * 32'h1c
        : i_seed * ({29'h0, i_addr[4:2]} + 32'h1);
    assign o_rdy = i_req & slow_r;
    // Inverted data while not ready, so a stale sample is never a match.
    assign o_data = o_rdy ? w : ~w;
endmodule

// [test_processor_init_and_error_signals.sv]
// Self-checking bench for the init sequencer.
`timescale 1ns/1ps
module test_processor_init_and_error_signals;
    import pis_pkg::*;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_interrupt0_pin = 1'b0, mem_bad = 1'b0;
    logic i_bad_access_in = 1'b0, i_bist_fault = 1'b0, i_start_cmd = 1'b0;
    logic i_last_ready = 1'b0, i_sync_op = 1'b0, i_mem_rdy, o_mem_req;
    logic o_failure_n_out, o_failure_n_oe, o_primary_bus_master, o_running;
    logic o_secondary_bus_master, o_stopped, o_fatal_err, o_recov_err;
    logic [3:0] i_int_req = 4'h0, o_int_latched, prv = 4'h0, exp_int = 4'h0;
    logic [3:0] now_v;
    logic [5:0] got_v;
    logic [31:0] i_mem_data, o_mem_addr, o_ptr_a, o_ptr_b;
    logic [31:0] seed = 32'h24ccb46f, rnd = 32'h24ccb46f;
    logic [5:0] q[$];
    int num_errors = 0, samples_checked = 0, seen = 0, cyc = 0;
    pis_top #(.BIST_LEN(8)) pis_top_inst (.*);
    pis_mem_model pis_mem_model_inst (.i_clk(i_clk), .i_req(o_mem_req),
        .i_addr(o_mem_addr), .i_seed(seed), .i_bad(mem_bad),
        .o_rdy(i_mem_rdy), .o_data(i_mem_data));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic scen(input logic role, st, bf, mb, input logic [5:0] e,
                        input int n);
        q.push_back(e);
        seed = xs(seed);
        i_rstn <= 1'b0;
        repeat (41) @(posedge i_clk);
        i_interrupt0_pin <= role;
        i_bad_access_in <= st;
        i_bist_fault <= bf;
        mem_bad <= mb;
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk({31'h0, o_secondary_bus_master}, {31'h0, ~role});
        chk({31'h0, o_failure_n_out}, 32'h0);
        i_interrupt0_pin <= 1'b0;
        i_bad_access_in <= 1'b0;
        if (!st) begin
            repeat (30) @(posedge i_clk);
            go();
        end
        repeat (300) if (seen < n) @(posedge i_clk);
    endtask
    task automatic go();
        i_start_cmd <= 1'b1;
        @(posedge i_clk);
        i_start_cmd <= 1'b0;
    endtask
    task automatic access(input logic s, b);
        i_last_ready <= 1'b1;
        @(posedge i_clk);
        i_last_ready <= 1'b0;
        i_bad_access_in <= b;
        i_sync_op <= s;
        @(posedge i_clk);
        i_bad_access_in <= 1'b0;
        i_sync_op <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        rnd <= xs(rnd);
        i_int_req <= rnd[3:0];
        exp_int <= (i_rstn && o_running) ? exp_int | i_int_req : 4'h0;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // Results are compared mid-cycle, once every edge update has landed.
    always @(negedge i_clk) begin
        now_v = {o_running, o_stopped, o_fatal_err, o_recov_err};
        got_v = {now_v, o_failure_n_oe, o_primary_bus_master};
        if (i_rstn && |(now_v & ~prv)) begin
            seen++;
            chk({26'h0, got_v}, {26'h0, q.pop_front()});
        end
        prv = now_v;
    end
    initial begin
        scen(1'b1, 1'b1, 1'b0, 1'b0, 6'b100001, 1);
        chk(o_ptr_a, seed * 32'h2);
        chk(o_ptr_b, seed * 32'h3);
        q.push_back(6'b101001);
        access(1'b0, 1'b1);
        q.push_back(6'b100101);
        access(1'b1, 1'b1);
        access(1'b0, 1'b0);
        scen(1'b0, 1'b1, 1'b0, 1'b1, 6'b010010, 4);
        go();
        scen(1'b1, 1'b1, 1'b1, 1'b0, 6'b010011, 5);
        scen(1'b0, 1'b0, 1'b0, 1'b0, 6'b100000, 6);
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        chk({28'h0, o_int_latched}, {28'h0, exp_int});
        chk(seen, 6);
        report_and_stop();
    end
endmodule
